// ### verilog/mts_pkg.sv
package mts_pkg;

    // clock and timeout timing
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned TIMEOUT_BASE_US = 128;
    localparam int unsigned TIMEOUT_BASE_CYC = (TIMEOUT_BASE_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned SEL_WIDTH       = 3;
    localparam int unsigned CNT_WIDTH       = 24;
    localparam int unsigned HIT_COUNT       = 6;
    localparam int unsigned TEMP_COUNT      = 4;
    localparam int unsigned RESULT_WIDTH    = 16;

    // code written into a result that cannot be trusted
    localparam logic [15:0] RESULT_INVALID  = 16'hFFFF;
    localparam logic [15:0] RESULT_RESET    = 16'h0000;

    // what the block is waiting for
    typedef enum logic [1:0] {
        MTS_WAIT_TOF,
        MTS_WAIT_HITS,
        MTS_WAIT_TEMP
    } mts_kind_t;

    // one measurement request
    typedef struct packed {
        logic              start;
        mts_kind_t         kind;
        logic [SEL_WIDTH-1:0] sel;
    } mts_req_t;

    // hits reported by the receive path
    typedef struct packed {
        logic              t1_edge;
        logic              t2_edge;
        logic [HIT_COUNT-1:0] hits;
        logic [TEMP_COUNT-1:0] temp_done;
    } mts_hits_t;

    // supervisor status toward software
    typedef struct packed {
        logic timeout_flag;
        logic irq;
        logic force_stop;
        logic busy;
    } mts_status_t;

endpackage

// ### verilog/mts_timer.sv
`timescale 1ns/1ps

// counts cycles since start and flags expiry of the selected interval
module mts_timer (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         run,
    input  wire logic                         restart,
    input  wire logic [mts_pkg::SEL_WIDTH-1:0] sel,
    output logic                              expired
);

    logic [mts_pkg::CNT_WIDTH-1:0] count_reg;
    logic [mts_pkg::CNT_WIDTH-1:0] limit;

    // interval doubles with each select step from the base length
    function automatic logic [mts_pkg::CNT_WIDTH-1:0] limit_of(
        input logic [mts_pkg::SEL_WIDTH-1:0] s
    );
        logic [mts_pkg::CNT_WIDTH-1:0] base;
        base = mts_pkg::CNT_WIDTH'(mts_pkg::TIMEOUT_BASE_CYC);
        return base << s;
    endfunction

    assign limit = limit_of(sel);

    // counter clears at every start so each measurement is timed alone
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (restart) begin
            count_reg <= '0;
        end else if (run && count_reg != limit) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign expired = run && (count_reg == limit);

endmodule

// ### verilog/mts_supervisor.sv
`timescale 1ns/1ps

module mts_supervisor (
    input  wire logic                            clk_sys,
    input  wire logic                            rst,
    input  wire mts_pkg::mts_req_t               req,
    input  wire mts_pkg::mts_hits_t              hit_in,
    input  wire logic [mts_pkg::HIT_COUNT-1:0]   hits_needed,
    input  wire logic [mts_pkg::TEMP_COUNT-1:0]  temp_needed,
    input  wire logic                            irq_enable,
    input  wire logic                            flag_clear,
    input  wire logic                            result_we,
    input  wire logic [1:0]                      result_idx,
    input  wire logic [mts_pkg::RESULT_WIDTH-1:0] result_data,
    input  wire logic [1:0]                      read_idx,
    output logic [mts_pkg::RESULT_WIDTH-1:0]     read_data,
    output logic [mts_pkg::RESULT_WIDTH-1:0]     temperature_result_one,
    output logic [mts_pkg::RESULT_WIDTH-1:0]     temperature_result_four,
    output mts_pkg::mts_status_t                 status
);

    typedef enum logic [1:0] {
        MTS_IDLE,
        MTS_RUN,
        MTS_STOP
    } mts_state_t;

    mts_state_t                          state_reg;
    mts_pkg::mts_kind_t                  kind_reg;
    logic [mts_pkg::SEL_WIDTH-1:0]       measurement_timeout_select;
    logic [mts_pkg::HIT_COUNT-1:0]       hits_seen_reg;
    logic [mts_pkg::TEMP_COUNT-1:0]      temp_seen_reg;
    logic [mts_pkg::HIT_COUNT-1:0]       hits_need_reg;
    logic [mts_pkg::TEMP_COUNT-1:0]      temp_need_reg;
    logic                                t1_seen_reg;
    logic                                t2_seen_reg;
    logic                                timeout_flag;
    logic                                irq_reg;
    logic                                stop_reg;
    logic                                busy_reg;
    logic [mts_pkg::CNT_WIDTH-1:0]       guard_cnt_reg;
    logic [mts_pkg::CNT_WIDTH-1:0]       guard_limit;
    logic                                expired;
    logic                                complete;
    logic                                timeout_ev;
    logic [mts_pkg::RESULT_WIDTH-1:0]    result_reg [mts_pkg::TEMP_COUNT];
    logic [mts_pkg::RESULT_WIDTH-1:0]    read_data_reg;
    logic [mts_pkg::TEMP_COUNT-1:0]      invalid_reg;

    // shared timer measures the interval from each start
    mts_timer u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (state_reg == MTS_RUN),
        .restart (req.start),
        .sel     (measurement_timeout_select),
        .expired (expired)
    );

    // the measurement is done when every hit it asked for has arrived
    always_comb begin
        unique case (kind_reg)
            mts_pkg::MTS_WAIT_TOF:  complete = t1_seen_reg && t2_seen_reg;
            mts_pkg::MTS_WAIT_HITS: complete = (hits_seen_reg & hits_need_reg) == hits_need_reg;
            default:                complete = (temp_seen_reg & temp_need_reg) == temp_need_reg;
        endcase
    end

    assign timeout_ev = (state_reg == MTS_RUN) && expired && !complete;

    // sequencing: a new start always restarts, even over a running one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= MTS_IDLE;
            busy_reg  <= 1'b0;
            kind_reg  <= mts_pkg::MTS_WAIT_TOF;
            measurement_timeout_select <= '0;
            hits_need_reg <= '0;
            temp_need_reg <= '0;
        end else if (req.start) begin
            state_reg <= MTS_RUN;
            busy_reg  <= 1'b1;
            kind_reg  <= req.kind;
            measurement_timeout_select <= req.sel;
            hits_need_reg <= hits_needed;
            temp_need_reg <= temp_needed;
        end else begin
            unique case (state_reg)
                MTS_IDLE: state_reg <= MTS_IDLE;
                MTS_RUN: begin
                    if (complete) begin
                        state_reg <= MTS_IDLE;
                        busy_reg  <= 1'b0;
                    end else if (expired) begin
                        state_reg <= MTS_STOP;
                        busy_reg  <= 1'b0;
                    end
                end
                MTS_STOP: state_reg <= MTS_IDLE;
            endcase
        end
    end

    // hit capture, cleared at each start
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hits_seen_reg <= '0;
            temp_seen_reg <= '0;
            t1_seen_reg   <= 1'b0;
            t2_seen_reg   <= 1'b0;
        end else if (req.start) begin
            hits_seen_reg <= '0;
            temp_seen_reg <= '0;
            t1_seen_reg   <= 1'b0;
            t2_seen_reg   <= 1'b0;
        end else if (state_reg == MTS_RUN) begin
            hits_seen_reg <= hits_seen_reg | hit_in.hits;
            temp_seen_reg <= temp_seen_reg | hit_in.temp_done;
            t1_seen_reg   <= t1_seen_reg | hit_in.t1_edge;
            t2_seen_reg   <= t2_seen_reg | hit_in.t2_edge;
        end
    end

    // forced stop pulse toward the converter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stop_reg <= 1'b0;
        end else begin
            stop_reg <= timeout_ev;
        end
    end

    // sticky flag: a new timeout wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timeout_flag <= 1'b0;
        end else if (timeout_ev) begin
            timeout_flag <= 1'b1;
        end else if (flag_clear) begin
            timeout_flag <= 1'b0;
        end
    end

    // interrupt follows the flag only while enabled
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_enable && (timeout_ev || (timeout_flag && !flag_clear));
        end
    end

    // result store; a temperature timeout writes ffff into needed slots still missing, other timeouts mark all slots to read back ffff
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < mts_pkg::TEMP_COUNT; i++) begin
                result_reg[i] <= mts_pkg::RESULT_RESET;
            end
            invalid_reg <= '0;
        end else begin
            if (req.start) begin
                invalid_reg <= '0;
            end else if (timeout_ev) begin
                for (int i = 0; i < mts_pkg::TEMP_COUNT; i++) begin
                    if (kind_reg == mts_pkg::MTS_WAIT_TEMP) begin
                        if (temp_need_reg[i] && !temp_seen_reg[i]) begin
                            result_reg[i] <= mts_pkg::RESULT_INVALID;
                        end
                    end else begin
                        invalid_reg[i] <= 1'b1;
                    end
                end
            end else if (result_we) begin
                result_reg[result_idx] <= result_data;
            end
        end
    end

    // readback masks results invalidated by a timed-out conversion
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            read_data_reg <= mts_pkg::RESULT_RESET;
        end else if (invalid_reg[read_idx]) begin
            read_data_reg <= mts_pkg::RESULT_INVALID;
        end else begin
            read_data_reg <= result_reg[read_idx];
        end
    end

    assign read_data               = read_data_reg;
    assign temperature_result_one  = result_reg[0];
    assign temperature_result_four = result_reg[3];
    assign status.timeout_flag     = timeout_flag;
    assign status.irq              = irq_reg;
    assign status.force_stop       = stop_reg;
    assign status.busy             = busy_reg;

    // longest run allowed for the select taken at the last start
    assign guard_limit = mts_pkg::CNT_WIDTH'(mts_pkg::TIMEOUT_BASE_CYC) << measurement_timeout_select;

    // cycles spent running, kept apart from the timer so a stuck timer shows up
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            guard_cnt_reg <= '0;
        end else if (req.start || state_reg != MTS_RUN) begin
            guard_cnt_reg <= '0;
        end else if (guard_cnt_reg <= guard_limit) begin
            guard_cnt_reg <= guard_cnt_reg + 1'b1; // saturates one past the limit
        end
    end

    chk_stop_on_timeout: assert property (@(posedge clk_sys) disable iff (rst)
        timeout_ev |=> stop_reg && timeout_flag) else $error("timeout without stop");
    chk_stop_has_cause: assert property (@(posedge clk_sys) disable iff (rst)
        stop_reg |-> $past(state_reg) == MTS_RUN && $past(expired))
        else $error("stop without expiry");
    chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        timeout_flag && !flag_clear |=> timeout_flag) else $error("flag lost");
    chk_flag_rise_cause: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(timeout_flag) |-> $past(timeout_ev)) else $error("flag rose alone");
    chk_irq_gated: assert property (@(posedge clk_sys) disable iff (rst)
        !irq_enable |=> !irq_reg) else $error("irq while disabled");
    chk_irq_asserts: assert property (@(posedge clk_sys) disable iff (rst)
        irq_enable && timeout_ev |=> irq_reg) else $error("irq missing");
    chk_invalid_read: assert property (@(posedge clk_sys) disable iff (rst)
        invalid_reg[read_idx] |=> read_data_reg == 16'hFFFF) else $error("bad read");
    chk_temp_open: assert property (@(posedge clk_sys) disable iff (rst)
        timeout_ev && kind_reg == mts_pkg::MTS_WAIT_TEMP && temp_need_reg[3]
        && !temp_seen_reg[3] |=> result_reg[3] == 16'hFFFF)
        else $error("open probe not marked");
    chk_timer_bound: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == MTS_RUN |-> guard_cnt_reg <= guard_limit) else $error("timeout late");

endmodule

// ### test/mts_supervisor_test.sv
`timescale 1ns/1ps

module mts_supervisor_test;
    // one ordinary measurement: inputs beside the outcome they should give
    typedef struct packed {
        mts_pkg::mts_kind_t kind;
        logic [2:0]         sel;
        logic [5:0]         hneed;
        logic [3:0]         tneed;
        logic [11:0]        hit;
        logic               irq_en;
        logic               exp_to;
    } mts_row_t;

    logic                 clk_sys;
    logic                 rst;
    mts_pkg::mts_req_t    req;
    mts_pkg::mts_hits_t   hit_in;
    logic [5:0]           hits_needed;
    logic [3:0]           temp_needed;
    logic                 irq_enable;
    logic                 flag_clear;
    logic                 result_we;
    logic [1:0]           result_idx;
    logic [15:0]          result_data;
    logic [1:0]           read_idx;
    logic [15:0]          read_data;
    logic [15:0]          temperature_result_one;
    logic [15:0]          temperature_result_four;
    mts_pkg::mts_status_t status;
    int                   n_fail;
    int                   total_checks;
    int                   n;

    // completion rows end a few cycles after their hits on cycle 5; timeout rows run the full interval
    mts_row_t rows [6] = '{
        '{mts_pkg::MTS_WAIT_TOF,  3'h0, 6'h00, 4'h0, 12'hC00, 1'b1, 1'b0},
        '{mts_pkg::MTS_WAIT_TOF,  3'h0, 6'h00, 4'h0, 12'h800, 1'b1, 1'b1},
        '{mts_pkg::MTS_WAIT_HITS, 3'h0, 6'h3F, 4'h0, 12'h3F0, 1'b1, 1'b0},
        '{mts_pkg::MTS_WAIT_HITS, 3'h0, 6'h3F, 4'h0, 12'h1F0, 1'b0, 1'b1},
        '{mts_pkg::MTS_WAIT_TEMP, 3'h0, 6'h00, 4'hF, 12'h00F, 1'b1, 1'b0},
        '{mts_pkg::MTS_WAIT_TOF,  3'h1, 6'h00, 4'h0, 12'h000, 1'b1, 1'b1}
    };

    mts_supervisor u_mts_supervisor (
        .clk_sys                 (clk_sys),
        .rst                     (rst),
        .req                     (req),
        .hit_in                  (hit_in),
        .hits_needed             (hits_needed),
        .temp_needed             (temp_needed),
        .irq_enable              (irq_enable),
        .flag_clear              (flag_clear),
        .result_we               (result_we),
        .result_idx              (result_idx),
        .result_data             (result_data),
        .read_idx                (read_idx),
        .read_data               (read_data),
        .temperature_result_one  (temperature_result_one),
        .temperature_result_four (temperature_result_four),
        .status                  (status)
    );

    // free-running 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            n_fail++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask

    // every driver works just after the rising edge, never on it
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse_clear();
        flag_clear = 1'b1;
        step();
        flag_clear = 1'b0;
    endtask

    task automatic write_slot(input logic [1:0] idx, input logic [15:0] data);
        result_we   = 1'b1;
        result_idx  = idx;
        result_data = data;
        step();
        result_we = 1'b0;
        step(); // let an edge pass so a following write raises the strobe afresh
    endtask

    // read data is registered, so it is looked at one edge after the select
    task automatic read_slot(input logic [1:0] idx, input logic [15:0] exp);
        read_idx = idx;
        step();
        check_word("read_data", exp, read_data);
    endtask

    // start a run, pulse the row's hits on cycle 5, stop when the run ends
    task automatic run_meas(input mts_row_t r, output int cnt);
        int lim;
        lim         = int'(mts_pkg::TIMEOUT_BASE_CYC) << r.sel;
        hits_needed = r.hneed;
        temp_needed = r.tneed;
        irq_enable  = r.irq_en;
        req         = '{start: 1'b1, kind: r.kind, sel: r.sel};
        step();
        req.start = 1'b0;
        cnt = 0;
        while (cnt < lim + 20) begin
            step();
            cnt++;
            hit_in = (cnt == 5) ? r.hit : 12'h000;
            if (status.force_stop === 1'b1 || status.busy === 1'b0) break;
        end
        if (cnt >= lim + 20) begin
            n_fail++;
            give_verdict();
        end
    endtask

    initial begin
        n_fail = 0;
        total_checks = 0;
        rst = 1'b1;
        req = '0;
        hit_in = '0;
        hits_needed = 6'h00;
        temp_needed = 4'h0;
        irq_enable = 1'b0;
        flag_clear = 1'b0;
        result_we = 1'b0;
        result_idx = 2'h0;
        result_data = 16'h0000;
        read_idx = 2'h0;
        repeat (2) step();
        check_word("status in reset", 16'h0000, 16'(status));
        check_word("temperature_result_one", 16'h0000, temperature_result_one);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            pulse_clear();
            run_meas(rows[i], n);
            check_bit("force_stop", rows[i].exp_to, status.force_stop);
            if (rows[i].exp_to) check_count("timeout cycles", (int'(mts_pkg::TIMEOUT_BASE_CYC) << rows[i].sel) + 1, n);
            if (!rows[i].exp_to) check_bit("early end", 1'b1, n < 100);
            step();
            check_bit("force_stop drop", 1'b0, status.force_stop);
            check_bit("busy", 1'b0, status.busy);
            check_bit("timeout_flag", rows[i].exp_to, status.timeout_flag);
            check_bit("irq", rows[i].exp_to & rows[i].irq_en, status.irq);
            if (rows[i].exp_to) for (int s = 0; s < 4; s++) read_slot(2'(s), 16'hFFFF);
        end
        // interrupt follows its enable while the flag stays set
        irq_enable = 1'b0;
        repeat (2) step();
        check_bit("irq masked", 1'b0, status.irq);
        irq_enable = 1'b1;
        repeat (2) step();
        check_bit("irq unmasked", 1'b1, status.irq);
        pulse_clear();
        step();
        check_bit("flag cleared", 1'b0, status.timeout_flag);
        check_bit("irq cleared", 1'b0, status.irq);
        // temperature run with slot 3 missing: only that slot is marked open
        write_slot(2'h0, 16'h1234);
        write_slot(2'h3, 16'h5678);
        run_meas('{mts_pkg::MTS_WAIT_TEMP, 3'h0, 6'h00, 4'h9, 12'h001, 1'b1, 1'b1}, n);
        check_count("temp timeout cycles", int'(mts_pkg::TIMEOUT_BASE_CYC) + 1, n);
        step();
        check_word("temperature_result_four", 16'hFFFF, temperature_result_four);
        check_word("temperature_result_one", 16'h1234, temperature_result_one);
        check_bit("temp timeout_flag", 1'b1, status.timeout_flag);
        read_slot(2'h3, 16'hFFFF);
        // reset in mid-run drops everything at once
        req = '{start: 1'b1, kind: mts_pkg::MTS_WAIT_TOF, sel: 3'h0};
        step();
        req.start = 1'b0;
        repeat (10) step();
        rst = 1'b1;
        #1;
        check_word("status after reset", 16'h0000, 16'(status));
        step();
        rst = 1'b0;
        step();
        check_word("status after release", 16'h0000, 16'(status));
        step();
        check_word("read_data after release", 16'h0000, read_data);
        give_verdict();
    end
endmodule
